// >>> lesf_pkg.sv
// Package: register map, field positions and reset values of the limit event flags
package lesf_pkg;
  // ********************
  // Register offsets
  // ********************
  localparam int LESF_IDX_FLAGS1 = 0;
  localparam int LESF_IDX_FLAGS2 = 1;
  localparam logic [7:0] LESF_OFF_FLAGS1 = 8'(LESF_IDX_FLAGS1 * 4);
  localparam logic [7:0] LESF_OFF_FLAGS2 = 8'(LESF_IDX_FLAGS2 * 4);
  localparam logic [7:0] LESF_OFF_MASK1 = 8'h08;
  localparam logic [7:0] LESF_OFF_MASK2 = 8'h0C;
  localparam logic [7:0] LESF_OFF_CTRL = 8'h10;
  localparam logic [7:0] LESF_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] LESF_OFF_IRQ_MASK = 8'h18;
  // ********************
  // Field positions
  // ********************
  localparam int LESF_B_INT_HI = 0;
  localparam int LESF_B_INT_LO = 1;
  localparam int LESF_B_EXT_HI = 2;
  localparam int LESF_B_EXT_LO = 3;
  localparam int LESF_B_EXT_FLT = 4;
  localparam int LESF_B_ANALOG_INPUT_TWO = 5;
  localparam int LESF_B_SUPPLY = 4;
  localparam int LESF_B_CTRL_SWRST = 0;
  localparam int LESF_B_CTRL_AINMODE = 1;
  // ********************
  // Reset values, used flag 2 bits and bus response codes
  // ********************
  localparam logic [7:0] LESF_RST_FLAGS = 8'h00;
  localparam logic [7:0] LESF_RST_MASK = 8'h00;
  localparam logic [1:0] LESF_RST_IRQ = 2'h0;
  localparam logic [7:0] LESF_FLAGS2_USED = 8'h10;
  localparam logic [1:0] LESF_RESP_OKAY = 2'h0;
  localparam logic [1:0] LESF_RESP_SLVERR = 2'h2;
endpackage : lesf_pkg

// >>> lesf_cmp_if.sv
// Interface: out-of-limit conditions from comparator to flag logic
`timescale 1ns/10ps
interface lesf_cmp_if;
  logic [7:0] cond1;
  logic [7:0] cond2;
  modport src (output cond1, output cond2);
  modport dst (input cond1, input cond2);
endinterface : lesf_cmp_if

// >>> lesf_compare.sv
// Limit comparator: turns results and limits into live out-of-limit conditions
`timescale 1ns/10ps
module lesf_compare #(
  parameter int W = 10
) (
  input wire logic ain_mode_in,
  input wire logic signed [W-1:0] int_temp_in,
  input wire logic signed [W-1:0] int_temp_upper_limit_in,
  input wire logic signed [W-1:0] int_temp_lower_limit_in,
  input wire logic [W-1:0] ext_result_in,
  input wire logic [W-1:0] ext_upper_limit_in,
  input wire logic [W-1:0] ext_lower_limit_in,
  input wire logic ext_fault_in,
  input wire logic [3*W-1:0] ain_result_in,
  input wire logic [3*W-1:0] ain_upper_in,
  input wire logic [3*W-1:0] ain_lower_in,
  input wire logic [W-1:0] supply_in,
  input wire logic [W-1:0] supply_upper_in,
  input wire logic [W-1:0] supply_lower_in,
  lesf_cmp_if.src cmp
);
  import lesf_pkg::*;
  // ********************
  // Window check, above upper or at or below lower
  // ********************
  function automatic logic outside(input logic [W-1:0] v, input logic [W-1:0] hi,
                                   input logic [W-1:0] lo);
    outside = (v > hi) || (v <= lo);
  endfunction : outside
  logic ext_hi;
  logic ext_lo;
  logic [2:0] ain_out;
  // External temperature is signed, analog input one unsigned
  assign ext_hi = $signed(ext_result_in) > $signed(ext_upper_limit_in);
  assign ext_lo = $signed(ext_result_in) <= $signed(ext_lower_limit_in);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ain
      assign ain_out[g] = outside(ain_result_in[g*W +: W], ain_upper_in[g*W +: W],
                                  ain_lower_in[g*W +: W]); // [R9]
    end
  endgenerate
  always_comb begin
    cmp.cond1 = 8'h00;
    cmp.cond1[LESF_B_INT_HI] = int_temp_in > int_temp_upper_limit_in; // [R3]
    cmp.cond1[LESF_B_INT_LO] = int_temp_in <= int_temp_lower_limit_in; // [R4]
    cmp.cond1[LESF_B_EXT_HI] = ain_mode_in ?
      outside(ext_result_in, ext_upper_limit_in, ext_lower_limit_in) : ext_hi; // [R5] [R6]
    cmp.cond1[LESF_B_EXT_LO] = !ain_mode_in && ext_lo; // [R7]
    cmp.cond1[LESF_B_EXT_FLT] = !ain_mode_in && ext_fault_in; // [R8]
    cmp.cond1[LESF_B_ANALOG_INPUT_TWO +: 3] = ain_out; // [R9]
    cmp.cond2 = 8'h00;
    cmp.cond2[LESF_B_SUPPLY] = outside(supply_in, supply_upper_in, supply_lower_in); // [R10]
  end
endmodule : lesf_compare

// >>> lesf_top.sv
// Limit event flag registers with AXI4-Lite access and interrupt output
//
// Notes on behaviour
// R1: Reading a flag register clears only those flags whose condition has gone away.
// R2: A software reset clears every flag in both flag registers; flags whose condition is still present set again.
// R3: Flag 1 bit 0 sets when internal temperature is above its upper limit.
// R4: Flag 1 bit 1 sets when internal temperature is at or below its lower limit.
// R5: In sensor mode flag 1 bit 2 sets when external temperature is above its upper limit.
// R6: In analog mode flag 1 bit 2 sets when input one is above upper or at or below lower limit.
// R7: Flag 1 bit 3 sets when external temperature is at or below its lower limit.
// R8: Flag 1 bit 4 sets on an open or short external sensor fault.
// R9: Flag 1 bits 5 to 7 set when inputs two to four leave their limit window.
// R10: Flag 2 bit 4 sets when the supply leaves its limit window.
// R11: Every flag can drive the interrupt output active.
// R12: Flag 2 bits other than bit 4 read zero and ignore changes.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module lesf_top #(
  parameter int W = 10
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic signed [W-1:0] int_temp_in,
  input wire logic signed [W-1:0] temp_upper_limit_in,
  input wire logic signed [W-1:0] temp_lower_limit_in,
  input wire logic [W-1:0] ext_result_in,
  input wire logic [W-1:0] ext_upper_limit_in,
  input wire logic [W-1:0] ext_lower_limit_in,
  input wire logic ext_fault_in,
  input wire logic [3*W-1:0] analog_input_result_in,
  input wire logic [3*W-1:0] volt_upper_limit_in,
  input wire logic [3*W-1:0] volt_lower_limit_in,
  input wire logic [W-1:0] supply_in,
  input wire logic [W-1:0] supply_upper_in,
  input wire logic [W-1:0] supply_lower_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic limit_int_out,
  output logic irq_out
);
  import lesf_pkg::*;
  // ********************
  // Storage
  // ********************
  logic [7:0] flags1;
  logic [7:0] flags2;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic ain_mode;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic swrst;
  logic rd_clr1;
  logic rd_clr2;
  logic [7:0] next_flags1;
  logic [7:0] next_flags2;
  logic [31:0] next_rdata;
  logic [1:0] next_resp;
  logic [1:0] events;
  logic limit_int_d;
  lesf_cmp_if cmp_bus ();
  // ********************
  // Comparators
  // ********************
  lesf_compare #(.W(W)) u_cmp (
    .ain_mode_in(ain_mode),
    .int_temp_in(int_temp_in),
    .int_temp_upper_limit_in(temp_upper_limit_in),
    .int_temp_lower_limit_in(temp_lower_limit_in),
    .ext_result_in(ext_result_in),
    .ext_upper_limit_in(ext_upper_limit_in),
    .ext_lower_limit_in(ext_lower_limit_in),
    .ext_fault_in(ext_fault_in),
    .ain_result_in(analog_input_result_in),
    .ain_upper_in(volt_upper_limit_in),
    .ain_lower_in(volt_lower_limit_in),
    .supply_in(supply_in),
    .supply_upper_in(supply_upper_in),
    .supply_lower_in(supply_lower_in),
    .cmp(cmp_bus.src)
  );
  // ********************
  // Write channel
  // ********************
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == LESF_OFF_FLAGS1) || (a == LESF_OFF_FLAGS2) || (a == LESF_OFF_MASK1) ||
                (a == LESF_OFF_MASK2) || (a == LESF_OFF_CTRL) || (a == LESF_OFF_IRQ_STAT) ||
                (a == LESF_OFF_IRQ_MASK);
  endfunction : is_mapped
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr_in[7:2], 2'b00};
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= LESF_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= is_mapped(aw_addr) ? LESF_RESP_OKAY : LESF_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end
  // ********************
  // Control registers
  // ********************
  assign swrst = wr_go && w_strb[0] && (aw_addr == LESF_OFF_CTRL) &&
                 w_data[LESF_B_CTRL_SWRST];
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask1 <= LESF_RST_MASK;
      mask2 <= LESF_RST_MASK;
      ain_mode <= 1'b0;
      irq_mask <= LESF_RST_IRQ;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == LESF_OFF_MASK1) begin
        mask1 <= w_data[7:0];
      end
      if (aw_addr == LESF_OFF_MASK2) begin
        mask2 <= w_data[7:0] & LESF_FLAGS2_USED;
      end
      if (aw_addr == LESF_OFF_CTRL) begin
        ain_mode <= w_data[LESF_B_CTRL_AINMODE];
      end
      if (aw_addr == LESF_OFF_IRQ_MASK) begin
        irq_mask <= w_data[1:0];
      end
    end
  end
  // ********************
  // Read channel
  // ********************
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_clr1 = rd_go && ({s_axi_araddr_in[7:2], 2'b00} == LESF_OFF_FLAGS1);
  assign rd_clr2 = rd_go && ({s_axi_araddr_in[7:2], 2'b00} == LESF_OFF_FLAGS2);
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_resp = LESF_RESP_OKAY;
    case ({s_axi_araddr_in[7:2], 2'b00})
      LESF_OFF_FLAGS1: next_rdata[7:0] = flags1;
      LESF_OFF_FLAGS2: next_rdata[7:0] = flags2 & LESF_FLAGS2_USED; // [R12]
      LESF_OFF_MASK1: next_rdata[7:0] = mask1;
      LESF_OFF_MASK2: next_rdata[7:0] = mask2;
      LESF_OFF_CTRL: next_rdata[LESF_B_CTRL_AINMODE] = ain_mode;
      LESF_OFF_IRQ_STAT: next_rdata[1:0] = irq_stat;
      LESF_OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: next_resp = LESF_RESP_SLVERR;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= LESF_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_resp;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
  // ********************
  // Limit event flags
  // ********************
  always_comb begin
    next_flags1 = flags1;
    next_flags2 = flags2;
    if (rd_clr1) begin
      next_flags1 = flags1 & cmp_bus.cond1; // [R1]
    end
    if (rd_clr2) begin
      next_flags2 = flags2 & cmp_bus.cond2; // [R1]
    end
    if (swrst) begin
      next_flags1 = LESF_RST_FLAGS; // [R2]
      next_flags2 = LESF_RST_FLAGS; // [R2]
    end
    next_flags1 = next_flags1 | cmp_bus.cond1; // [R3] [R4] [R5] [R6] [R7] [R8] [R9]
    next_flags2 = (next_flags2 | cmp_bus.cond2) & LESF_FLAGS2_USED; // [R10] [R12]
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags1 <= LESF_RST_FLAGS;
      flags2 <= LESF_RST_FLAGS;
    end else begin
      flags1 <= next_flags1;
      flags2 <= next_flags2;
    end
  end
  // ********************
  // Interrupt pin and bus interrupt
  // ********************
  assign limit_int_d = |(flags1 & ~mask1) || |(flags2 & ~mask2); // [R11]
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      limit_int_out <= 1'b0;
    end else begin
      limit_int_out <= limit_int_d; // [R11]
    end
  end
  assign events = {|(next_flags2 & ~flags2), |(next_flags1 & ~flags1)};
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat <= LESF_RST_IRQ;
    end else if (wr_go && w_strb[0] && aw_addr == LESF_OFF_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~w_data[1:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end
  assign irq_out = |(irq_stat & irq_mask);
  // ********************
  // Checks
  // ********************
  a_flag1_sets: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R3]
    (cmp_bus.cond1 != 8'h00) |=> ((flags1 & $past(cmp_bus.cond1)) == $past(cmp_bus.cond1)))
    else $error("flag 1 missed a condition");
  a_read_keeps: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R1]
    (rd_clr1 && !swrst) |=> (flags1 == $past(cmp_bus.cond1)))
    else $error("read did not clear gone flags");
  a_swrst_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R2]
    swrst |=> (flags1 == $past(cmp_bus.cond1)) && (flags2 == $past(cmp_bus.cond2)))
    else $error("software reset left flags");
  a_flags2_unused: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R12]
    (flags2 & ~LESF_FLAGS2_USED) == 8'h00)
    else $error("unused flag 2 bit set");
  a_supply_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R10]
    cmp_bus.cond2[LESF_B_SUPPLY] |=> flags2[LESF_B_SUPPLY])
    else $error("supply flag not set");
  a_int_follows: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R11]
    ((flags1 & ~mask1) != 8'h00) |=> limit_int_out)
    else $error("interrupt pin not driven");
  a_ext_mode: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R7]
    ain_mode |-> !cmp_bus.cond1[LESF_B_EXT_LO] && !cmp_bus.cond1[LESF_B_EXT_FLT])
    else $error("sensor bits live in analog mode");
  a_ain_window: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [R9]
    (analog_input_result_in[W-1:0] <= volt_lower_limit_in[W-1:0]) |=> flags1[LESF_B_ANALOG_INPUT_TWO])
    else $error("input two low flag missing");
  a_int_upper: assert property ( // [R3]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (int_temp_in > temp_upper_limit_in) |=> flags1[LESF_B_INT_HI])
    else $error("internal upper flag missing");
  a_int_lower: assert property ( // [R4]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (int_temp_in <= temp_lower_limit_in) |=> flags1[LESF_B_INT_LO])
    else $error("internal lower flag missing");
  a_ext_upper: assert property ( // [R5]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!ain_mode && ($signed(ext_result_in) > $signed(ext_upper_limit_in))) |=> flags1[2])
    else $error("external upper flag missing");
  a_input_one: assert property ( // [R6]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (ain_mode && ((ext_result_in > ext_upper_limit_in) ||
    (ext_result_in <= ext_lower_limit_in))) |=> flags1[LESF_B_EXT_HI])
    else $error("input one flag missing");
  a_ext_lower: assert property ( // [R7]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!ain_mode && ($signed(ext_result_in) <= $signed(ext_lower_limit_in))) |=> flags1[3])
    else $error("external lower flag missing");
  a_ext_fault: assert property ( // [R8]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!ain_mode && ext_fault_in) |=> flags1[LESF_B_EXT_FLT])
    else $error("sensor fault flag missing");
  a_read_keeps_two: assert property ( // [R1]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (rd_clr2 && !swrst) |=> (flags2 == $past(cmp_bus.cond2)))
    else $error("read did not clear gone flag 2");
  a_flags1_sticky: assert property ( // [R1]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!rd_clr1 && !swrst) |=> ((flags1 & $past(flags1)) == $past(flags1)))
    else $error("flag 1 dropped without clear");
  a_flags2_sticky: assert property ( // [R1]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!rd_clr2 && !swrst) |=> ((flags2 & $past(flags2)) == $past(flags2)))
    else $error("flag 2 dropped without clear");
  a_int_two: assert property ( // [R11]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    ((flags2 & ~mask2) != 8'h00) |=> limit_int_out)
    else $error("flag 2 did not drive pin");
  a_int_quiet: assert property ( // [R11]
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (((flags1 & ~mask1) == 8'h00) && ((flags2 & ~mask2) == 8'h00)) |=> !limit_int_out)
    else $error("interrupt pin high without flag");
  // ********************
  // Bus and event checks
  // ********************
  a_irq_sets: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (events != 2'b00) |=> ((irq_stat & $past(events)) == $past(events)))
    else $error("event status bit not set");
  a_read_answer: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    rd_go |=> s_axi_rvalid_out)
    else $error("read not answered");
  a_rvalid_holds: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (s_axi_rvalid_out && !s_axi_rready_in) |=> (s_axi_rvalid_out && $stable(s_axi_rdata_out)))
    else $error("read answer dropped early");
  a_bvalid_holds: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out)
    else $error("write answer dropped early");
endmodule : lesf_top

// >>> lesf_host.sv
// Host model: AXI4-Lite master reaching the limit event flag registers
`timescale 1ns/10ps
module lesf_host (
  input wire logic clk_in,
  output logic [7:0] awaddr_out = 8'h00,
  output logic awvalid_out = 1'b0,
  input wire logic awready_in,
  output logic [31:0] wdata_out = 32'h0,
  output logic [3:0] wstrb_out = 4'hF,
  output logic wvalid_out = 1'b0,
  input wire logic wready_in,
  input wire logic bvalid_in,
  input wire logic [1:0] bresp_in,
  output logic bready_out = 1'b0,
  output logic [7:0] araddr_out = 8'h00,
  output logic arvalid_out = 1'b0,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out = 1'b0,
  output logic timeout_out = 1'b0
);
  logic [1:0] wresp = 2'h0;
  // ********************
  // Bus cycles, each held until its own ready
  // ********************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk_in);
    awaddr_out <= a;
    awvalid_out <= 1'b1;
    wdata_out <= d;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_in);
      aw_hs = awvalid_out && awready_in;
      w_hs = wvalid_out && wready_in;
      b_hs = bvalid_in;
      if (bvalid_in) wresp = bresp_in;
      @(posedge clk_in);
      if (aw_hs) awvalid_out <= 1'b0;
      if (w_hs) wvalid_out <= 1'b0;
      if (b_hs) begin
        bready_out <= 1'b0;
        return;
      end
    end
    timeout_out <= 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_in);
      ar_hs = arvalid_out && arready_in;
      r_hs = rvalid_in;
      d = rdata_in;
      r = rresp_in;
      @(posedge clk_in);
      if (ar_hs) arvalid_out <= 1'b0;
      if (r_hs) begin
        rready_out <= 1'b0;
        return;
      end
    end
    timeout_out <= 1'b1;
  endtask : rd
endmodule : lesf_host

// >>> tb.sv
// Testbench: flag setting, read clear, software reset and interrupts
`timescale 1ns/10ps
module tb;
  import lesf_pkg::*;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, ext_fault_in;
  logic signed [9:0] int_temp_in, temp_upper_limit_in, temp_lower_limit_in;
  logic [9:0] ext_result_in, ext_upper_limit_in, ext_lower_limit_in;
  logic [9:0] supply_in, supply_upper_in, supply_lower_in;
  logic [29:0] analog_input_result_in, volt_upper_limit_in, volt_lower_limit_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in, limit_int_out, irq_out, host_timeout;
  int err_count = 0, n_checks = 0;
  localparam logic [7:0] EXP1 [11] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
    8'h40, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] EXP2 [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h10, 8'h10};
  always #10 core_clk_in = ~core_clk_in;
  lesf_top #(.W(10)) lesf_top_i (.core_clk_in, .arst_n_in, .int_temp_in, .temp_upper_limit_in,
    .temp_lower_limit_in, .ext_result_in, .ext_upper_limit_in, .ext_lower_limit_in,
    .ext_fault_in, .analog_input_result_in, .volt_upper_limit_in, .volt_lower_limit_in,
    .supply_in, .supply_upper_in, .supply_lower_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .limit_int_out, .irq_out);
  lesf_host lesf_host_i (.clk_in(core_clk_in), .awaddr_out(s_axi_awaddr_in),
    .awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out), .wdata_out(s_axi_wdata_in),
    .wstrb_out(s_axi_wstrb_in), .wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out),
    .bvalid_in(s_axi_bvalid_out), .bresp_in(s_axi_bresp_out), .bready_out(s_axi_bready_in),
    .araddr_out(s_axi_araddr_in),
    .arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out),
    .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out), .rready_out(s_axi_rready_in),
    .timeout_out(host_timeout));
  // ********************
  // Stimulus and comparison tasks
  // ********************
  task automatic base();
    int_temp_in <= 10'sd0;
    temp_upper_limit_in <= 10'sd100;
    temp_lower_limit_in <= -10'sd50;
    {ext_result_in, ext_upper_limit_in, ext_lower_limit_in} <= {10'd50, 10'd100, 10'd10};
    ext_fault_in <= 1'b0;
    analog_input_result_in <= {3{10'd50}};
    volt_upper_limit_in <= {3{10'd100}};
    volt_lower_limit_in <= {3{10'd10}};
    {supply_in, supply_upper_in, supply_lower_in} <= {10'd50, 10'd100, 10'd10};
  endtask : base

  task automatic apply(input int k);
    case (k)
      0: int_temp_in <= 10'sd101;
      1: int_temp_in <= 10'sd100;
      2: int_temp_in <= -10'sd50;
      3: ext_result_in <= 10'd101;
      4: ext_result_in <= 10'd10;
      5: ext_fault_in <= 1'b1;
      6: analog_input_result_in <= {10'd50, 10'd50, 10'd101};
      7: analog_input_result_in <= {10'd50, 10'd10, 10'd50};
      8: analog_input_result_in <= {10'd101, 10'd50, 10'd50};
      9: supply_in <= 10'd10;
      default: supply_in <= 10'd101;
    endcase
  endtask : apply

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    lesf_host_i.rd(a, d, r);
    chk(n, e, d);
    chk(n, {30'h0, LESF_RESP_OKAY}, {30'h0, r});
  endtask : rc

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask : settle

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge core_clk_in) begin
    if (host_timeout === 1'b1) begin
      err_count++;
      complete_run();
    end
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    base();
    repeat (3) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rc("flags1", LESF_OFF_FLAGS1, 32'h0);
    rc("flags2", LESF_OFF_FLAGS2, 32'h0);
    rc("mask1", LESF_OFF_MASK1, 32'h0);
    lesf_host_i.rd(8'h40, d, r);
    chk("unmapped resp", {30'h0, LESF_RESP_SLVERR}, {30'h0, r});
    lesf_host_i.wr(8'h40, 32'h1);
    chk("unmapped bresp", {30'h0, LESF_RESP_SLVERR}, {30'h0, lesf_host_i.wresp});
    for (int k = 0; k < 11; k++) begin
      @(posedge core_clk_in);
      apply(k);
      settle(3);
      chk("limit_int", {31'h0, (EXP1[k] | EXP2[k]) != 8'h00}, {31'h0, limit_int_out});
      @(posedge core_clk_in);
      base();
      rc("flags1 set", LESF_OFF_FLAGS1, {24'h0, EXP1[k]});
      rc("flags2 set", LESF_OFF_FLAGS2, {24'h0, EXP2[k]});
      rc("flags1 clr", LESF_OFF_FLAGS1, 32'h0);
      rc("flags2 clr", LESF_OFF_FLAGS2, 32'h0);
    end
    @(posedge core_clk_in);
    apply(0);
    rc("persist", LESF_OFF_FLAGS1, 32'h1);
    rc("persist", LESF_OFF_FLAGS1, 32'h1);
    base();
    rc("gone", LESF_OFF_FLAGS1, 32'h1);
    rc("gone", LESF_OFF_FLAGS1, 32'h0);
    lesf_host_i.wr(LESF_OFF_CTRL, 32'h2);
    chk("ctrl bresp", {30'h0, LESF_RESP_OKAY}, {30'h0, lesf_host_i.wresp});
    ext_result_in <= 10'd5;
    settle(2);
    @(posedge core_clk_in);
    base();
    rc("analog mode", LESF_OFF_FLAGS1, 32'h4);
    lesf_host_i.wr(LESF_OFF_CTRL, 32'h0);
    @(posedge core_clk_in);
    int_temp_in <= 10'sd101;
    supply_in <= 10'd10;
    settle(2);
    @(posedge core_clk_in);
    base();
    lesf_host_i.wr(LESF_OFF_CTRL, 32'h1);
    rc("swrst flags1", LESF_OFF_FLAGS1, 32'h0);
    rc("swrst flags2", LESF_OFF_FLAGS2, 32'h0);
    lesf_host_i.wr(LESF_OFF_FLAGS2, 32'hFF);
    rc("flags2 unused", LESF_OFF_FLAGS2, 32'h0);
    lesf_host_i.wr(LESF_OFF_IRQ_STAT, 32'h3);
    rc("irq stat clr", LESF_OFF_IRQ_STAT, 32'h0);
    lesf_host_i.wr(LESF_OFF_IRQ_MASK, 32'h3);
    @(posedge core_clk_in);
    int_temp_in <= 10'sd101;
    settle(3);
    chk("irq", 32'h1, {31'h0, irq_out});
    @(posedge core_clk_in);
    base();
    rc("irq stat", LESF_OFF_IRQ_STAT, 32'h1);
    lesf_host_i.wr(LESF_OFF_IRQ_STAT, 32'h1);
    settle(1);
    chk("irq cleared", 32'h0, {31'h0, irq_out});
    lesf_host_i.wr(LESF_OFF_MASK1, 32'hFF);
    settle(2);
    chk("masked limit_int", 32'h0, {31'h0, limit_int_out});
    rc("mask1", LESF_OFF_MASK1, 32'hFF);
    rc("flags1 masked", LESF_OFF_FLAGS1, 32'h1);
    complete_run();
  end
endmodule : tb
